// File: jmp_cfg.svh
// Constants of the test-port programming block.
// Assumes inclusion by the package, the design module and the bench.
`ifndef JMP_CFG_SVH
`define JMP_CFG_SVH
`define JMP_IR_W          4
`define JMP_IR_RESET      4'hc
`define JMP_IR_UNLOCK     4'h4
`define JMP_IR_COMMAND    4'h5
`define JMP_IR_PAGE_LOAD  4'h6
`define JMP_IR_PAGE_READ  4'h7
`define JMP_IR_BYPASS     4'hf
`define JMP_IR_CAPTURE    4'h1
`define JMP_KEY_W         16
`define JMP_KEY           16'ha370
`define JMP_CMD_W         15
`define JMP_BYTE_W        8
`define JMP_ADDR_W        16
`define JMP_LOAD_TCK      11
`define JMP_DIS_CLKS      2
`define JMP_TIMEOUT_CLKS  64
`endif

// File: jmp_pkg.sv
// Types of the test-port programming block.
// Assumes jmp_cfg.svh is in the include path.
`include "jmp_cfg.svh"
package jmp_pkg;
	typedef enum logic [3:0] {
		TAP_RESET  = 4'h0,
		TAP_IDLE   = 4'h1,
		TAP_SEL_DR = 4'h2,
		TAP_CAP_DR = 4'h3,
		TAP_SH_DR  = 4'h4,
		TAP_EX1_DR = 4'h5,
		TAP_PA_DR  = 4'h6,
		TAP_EX2_DR = 4'h7,
		TAP_UPD_DR = 4'h8,
		TAP_SEL_IR = 4'h9,
		TAP_CAP_IR = 4'ha,
		TAP_SH_IR  = 4'hb,
		TAP_EX1_IR = 4'hc,
		TAP_PA_IR  = 4'hd,
		TAP_EX2_IR = 4'he,
		TAP_UPD_IR = 4'hf
	} jmp_tap_t;

	// Test port pins
	typedef struct packed {
		logic tms;
		logic tdi;
	} jmp_pins_in_t;

	typedef struct packed {
		logic tdo;
		logic tdo_oe;
	} jmp_pins_out_t;

	// Memory side, in the system clock domain
	typedef struct packed {
		logic [`JMP_CMD_W-1:0]  cmd;
		logic                   cmd_exec;
		logic                   load_wr;
		logic                   load_high;
		logic [`JMP_BYTE_W-1:0] load_data;
		logic [`JMP_ADDR_W-1:0] addr;
	} jmp_mem_req_t;
endpackage

// File: jmp_sync.sv
// Two-stage level synchroniser.
// Assumes an asynchronous active-high reset of the target domain.
module jmp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] out_q;
	logic [W-1:0] out_d;

	initial begin
		if (W < 1) begin
			$error("jmp_sync width must be positive");
		end
	end

	always_comb begin
		meta_d = din;
		out_d  = meta_q;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			out_q  <= '0;
		end else begin
			meta_q <= meta_d;
			out_q  <= out_d;
		end
	end

	assign dout = out_q;
endmodule

// File: jmp_port.sv
// Test access port with programming data registers.
// Assumes tck is the link clock; sys_clk runs the chip side; rst is
// power-on reset; memory answers arrive on sys_clk.
`include "jmp_cfg.svh"
module jmp_port #(
	parameter int ADDR_W = `JMP_ADDR_W
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic                   tck,
	input  wire jmp_pkg::jmp_pins_in_t  pins_in,
	output jmp_pkg::jmp_pins_out_t      pins_out,
	input  wire logic                   test_port_enable_fuse,
	input  wire logic                   ext_reset_n,
	input  wire logic                   disable_set,
	input  wire logic [`JMP_CMD_W-1:0]  cmd_result,
	input  wire logic [`JMP_BYTE_W-1:0] read_byte,
	input  wire logic [ADDR_W-1:0]      addr_load,
	input  wire logic                   addr_load_en,
	output jmp_pkg::jmp_mem_req_t       mem_req,
	output logic                        test_port_disable_bit,
	output logic                        port_usable,
	output logic                        chip_reset,
	output logic                        prog_mode
);
	import jmp_pkg::*;

	initial begin
		if (ADDR_W != `JMP_ADDR_W) begin
			$error("jmp_port address width must match the memory map");
		end
	end

	// ------------------------------------------------------------
	// Chip clock side: disable bit, reset timing
	// ------------------------------------------------------------
	logic       ext_rst_s;
	logic [1:0] dis_cnt_q;
	logic [1:0] dis_cnt_d;
	logic       dis_q;
	logic       dis_d;
	logic       chain_s;
	logic       reset_chain_q;
	logic       reset_chain_d;
	logic [7:0] tout_q;
	logic [7:0] tout_d;

	jmp_sync #(.W(2)) u_sync_rst (
		.clk  (sys_clk),
		.rst  (rst),
		.din  ({~ext_reset_n, reset_chain_q}),
		.dout ({ext_rst_s, chain_s})
	);

	always_comb begin
		dis_d     = dis_q;
		dis_cnt_d = 2'h0;
		tout_d    = tout_q;
		if (ext_rst_s) begin
			if (dis_q) begin
				dis_cnt_d = dis_cnt_q + 2'h1;
			end
			if (dis_cnt_q == 2'(`JMP_DIS_CLKS - 1)) begin
				dis_d = 1'b0;
			end
		end else if (disable_set) begin
			dis_d = 1'b1;
		end
		if (chain_s || ext_rst_s) begin
			tout_d = 8'(`JMP_TIMEOUT_CLKS);
		end else if (tout_q != 8'h0) begin
			tout_d = tout_q - 8'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dis_q     <= 1'b0;
			dis_cnt_q <= 2'h0;
			tout_q    <= 8'h0;
		end else begin
			dis_q     <= dis_d;
			dis_cnt_q <= dis_cnt_d;
			tout_q    <= tout_d;
		end
	end

	assign test_port_disable_bit = dis_q;
	assign port_usable = test_port_enable_fuse & ~dis_q;
	// Immediate: unsynchronised chain output drives the reset
	assign chip_reset = reset_chain_q | (tout_q != 8'h0);

	logic usable_t;
	jmp_sync #(.W(1)) u_sync_use (
		.clk  (tck),
		.rst  (rst),
		.din  (port_usable),
		.dout (usable_t)
	);

	// ------------------------------------------------------------
	// TAP controller on tck
	// ------------------------------------------------------------
	jmp_tap_t tap_q;
	jmp_tap_t tap_d;
	logic     tms;

	assign tms = pins_in.tms;

	always_comb begin
		tap_d = tap_q;
		case (tap_q)
			TAP_RESET:  tap_d = tms ? TAP_RESET  : TAP_IDLE;
			TAP_IDLE:   tap_d = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_d = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_d = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR:  tap_d = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_d = tms ? TAP_UPD_DR : TAP_PA_DR;
			TAP_PA_DR:  tap_d = tms ? TAP_EX2_DR : TAP_PA_DR;
			TAP_EX2_DR: tap_d = tms ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: tap_d = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_d = tms ? TAP_RESET  : TAP_CAP_IR;
			TAP_CAP_IR: tap_d = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR:  tap_d = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_d = tms ? TAP_UPD_IR : TAP_PA_IR;
			TAP_PA_IR:  tap_d = tms ? TAP_EX2_IR : TAP_PA_IR;
			TAP_EX2_IR: tap_d = tms ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: tap_d = tms ? TAP_SEL_DR : TAP_IDLE;
			default:    tap_d = TAP_RESET;
		endcase
		if (!usable_t) begin
			tap_d = TAP_RESET;
		end
	end

	// ------------------------------------------------------------
	// Instruction and data registers on tck
	// ------------------------------------------------------------
	logic [`JMP_IR_W-1:0]   ir_sh_q, ir_sh_d, ir_q, ir_d;
	logic                   addr_tg_q, addr_tg_d;
	logic                   cmd_tg_q, cmd_tg_d;
	logic                   addr_ld_t;
	logic                   bypass_q, bypass_d;
	logic [`JMP_KEY_W-1:0]  key_sh_q, key_sh_d;
	logic                   unlock_q, unlock_d;
	logic [`JMP_CMD_W-1:0]  cmd_sh_q, cmd_sh_d;
	logic [`JMP_CMD_W-1:0]  cmd_q, cmd_d;
	logic                   exec_tg_q, exec_tg_d;
	logic                   load_tg_q, load_tg_d;
	logic [`JMP_BYTE_W-1:0] tmp_q, tmp_d;
	logic                   hi_q, hi_d;
	logic                   first_q, first_d;
	logic [ADDR_W-1:0]      addr_q, addr_d;
	logic                   tdo_q, tdo_d;
	logic                   tdi;

	assign tdi = pins_in.tdi;

	function automatic logic [`JMP_CMD_W-1:0] shr_cmd(
		input logic [`JMP_CMD_W-1:0] v, input logic b, input logic byte_only);
		logic [`JMP_CMD_W-1:0] r;
		r = {b, v[`JMP_CMD_W-1:1]};
		if (byte_only) begin
			r = {v[`JMP_CMD_W-1:`JMP_BYTE_W], b, v[`JMP_BYTE_W-1:1]};
		end
		return r;
	endfunction

	logic in_prog;
	assign in_prog = unlock_q;

	always_comb begin
		ir_sh_d       = ir_sh_q;
		ir_d          = ir_q;
		reset_chain_d = reset_chain_q;
		bypass_d      = bypass_q;
		key_sh_d      = key_sh_q;
		unlock_d      = unlock_q;
		cmd_sh_d      = cmd_sh_q;
		cmd_d         = cmd_q;
		exec_tg_d     = exec_tg_q;
		load_tg_d     = load_tg_q;
		cmd_tg_d      = cmd_tg_q;
		tmp_d         = tmp_q;
		hi_d          = hi_q;
		first_d       = first_q;
		addr_d        = addr_q;
		tdo_d         = tdo_q;
		case (tap_q)
			TAP_RESET: begin
				ir_d = `JMP_IR_BYPASS;
			end
			TAP_CAP_IR: begin
				ir_sh_d = `JMP_IR_CAPTURE;
			end
			TAP_SH_IR: begin
				ir_sh_d = {tdi, ir_sh_q[`JMP_IR_W-1:1]};
			end
			TAP_UPD_IR: begin
				ir_d    = ir_sh_q;
				hi_d    = 1'b0;
				first_d = 1'b1;
			end
			TAP_IDLE: begin
				if (ir_q == `JMP_IR_COMMAND && in_prog) begin
					exec_tg_d = ~exec_tg_q;
				end
			end
			TAP_CAP_DR: begin
				if (ir_q == `JMP_IR_COMMAND) begin
					cmd_sh_d = cmd_result;
				end else if (ir_q == `JMP_IR_PAGE_READ && in_prog) begin
					cmd_sh_d[`JMP_BYTE_W-1:0] = read_byte;
					hi_d = ~hi_q;
					if (hi_q) begin
						addr_d = addr_q + 1'b1;
					end
				end
			end
			TAP_SH_DR: begin
				if (ir_q == `JMP_IR_RESET) begin
					reset_chain_d = tdi;
				end else if (ir_q == `JMP_IR_UNLOCK) begin
					key_sh_d = {tdi, key_sh_q[`JMP_KEY_W-1:1]};
				end else if (ir_q == `JMP_IR_COMMAND) begin
					cmd_sh_d = shr_cmd(cmd_sh_q, tdi, 1'b0);
				end else if (ir_q == `JMP_IR_PAGE_LOAD ||
					ir_q == `JMP_IR_PAGE_READ) begin
					cmd_sh_d = shr_cmd(cmd_sh_q, tdi, 1'b1);
				end else begin
					bypass_d = tdi;
				end
			end
			TAP_UPD_DR: begin
				if (ir_q == `JMP_IR_UNLOCK) begin
					unlock_d = (key_sh_q == `JMP_KEY);
				end else if (ir_q == `JMP_IR_COMMAND && in_prog) begin
					cmd_d = cmd_sh_q;
					cmd_tg_d = ~cmd_tg_q;
				end else if (ir_q == `JMP_IR_PAGE_LOAD && in_prog) begin
					tmp_d     = cmd_sh_q[`JMP_BYTE_W-1:0];
					load_tg_d = ~load_tg_q;
					hi_d      = ~hi_q;
					first_d   = 1'b0;
					if (!hi_q && !first_q) begin
						addr_d = addr_q + 1'b1;
					end
				end
			end
			default: begin
			end
		endcase
		// Shift output: LSB of the selected register
		if (tap_q == TAP_SH_IR) begin
			tdo_d = ir_sh_q[0];
		end else if (tap_q == TAP_SH_DR) begin
			if (ir_q == `JMP_IR_RESET) begin
				tdo_d = reset_chain_q;
			end else if (ir_q == `JMP_IR_UNLOCK) begin
				tdo_d = key_sh_q[0];
			end else if (ir_q == `JMP_IR_COMMAND || ir_q == `JMP_IR_PAGE_LOAD ||
				ir_q == `JMP_IR_PAGE_READ) begin
				tdo_d = cmd_sh_q[0];
			end else begin
				tdo_d = bypass_q;
			end
		end
		// Chip side preload; any address change is flagged for the chip
		if (addr_ld_t) begin
			addr_d = addr_load;
		end
		addr_tg_d = addr_tg_q ^ (addr_d != addr_q);
	end

	// Address handed over as a quasi-static word when chip side loads it
	jmp_sync #(.W(1)) u_sync_ald (
		.clk  (tck),
		.rst  (rst),
		.din  (addr_load_en),
		.dout (addr_ld_t)
	);

	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			tap_q         <= TAP_RESET;
			ir_sh_q       <= '0;
			ir_q          <= `JMP_IR_BYPASS;
			reset_chain_q <= 1'b0;
			bypass_q      <= 1'b0;
			key_sh_q      <= '0;
			unlock_q      <= 1'b0;
			cmd_sh_q      <= '0;
			cmd_q         <= '0;
			exec_tg_q     <= 1'b0;
			load_tg_q     <= 1'b0;
			addr_tg_q     <= 1'b0;
			cmd_tg_q      <= 1'b0;
			tmp_q         <= '0;
			hi_q          <= 1'b0;
			first_q       <= 1'b1;
			addr_q        <= '0;
			tdo_q         <= 1'b0;
		end else begin
			tap_q         <= tap_d;
			ir_sh_q       <= ir_sh_d;
			ir_q          <= ir_d;
			reset_chain_q <= reset_chain_d;
			bypass_q      <= bypass_d;
			key_sh_q      <= key_sh_d;
			unlock_q      <= unlock_d;
			cmd_sh_q      <= cmd_sh_d;
			cmd_q         <= cmd_d;
			exec_tg_q     <= exec_tg_d;
			load_tg_q     <= load_tg_d;
			addr_tg_q     <= addr_tg_d;
			cmd_tg_q      <= cmd_tg_d;
			tmp_q         <= tmp_d;
			hi_q          <= hi_d;
			first_q       <= first_d;
			addr_q        <= addr_d;
			tdo_q         <= tdo_d;
		end
	end

	assign pins_out.tdo    = tdo_q;
	assign pins_out.tdo_oe = (tap_q == TAP_SH_DR) || (tap_q == TAP_SH_IR);
	assign prog_mode       = unlock_q;

	// ------------------------------------------------------------
	// Events into the chip clock domain by toggle
	// ------------------------------------------------------------
	// Each word stands still from its toggle until the next one
	logic [3:0]   tg_s;
	logic [3:0]   evt;
	logic [3:0]   tg_last_q, tg_last_d;
	jmp_mem_req_t req_q, req_d;

	jmp_sync #(.W(4)) u_sync_tg (
		.clk  (sys_clk),
		.rst  (rst),
		.din  ({exec_tg_q, load_tg_q, addr_tg_q, cmd_tg_q}),
		.dout (tg_s)
	);

	always_comb begin
		tg_last_d      = tg_s;
		evt            = tg_s ^ tg_last_q;
		req_d          = req_q;
		req_d.cmd_exec = evt[3];
		req_d.load_wr  = evt[2];
		if (evt[0]) begin
			req_d.cmd = cmd_q;
		end
		if (evt[1] || evt[2]) begin
			req_d.addr = addr_q;
		end
		if (evt[2]) begin
			req_d.load_data = tmp_q;
			req_d.load_high = ~hi_q;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tg_last_q <= 4'h0;
			req_q     <= '0;
		end else begin
			tg_last_q <= tg_last_d;
			req_q     <= req_d;
		end
	end

	assign mem_req = req_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_upd_unlock;
		tap_q == TAP_UPD_DR && ir_q == `JMP_IR_UNLOCK;
	endsequence

	a_unlock_on_key: assert property (
		@(posedge tck) disable iff (rst)
		s_upd_unlock |=> unlock_q == $past(key_sh_q == `JMP_KEY))
		else $error("unlock does not follow key compare");
	a_unlock_hold: assert property (
		@(posedge tck) disable iff (rst)
		!(tap_q == TAP_UPD_DR && ir_q == `JMP_IR_UNLOCK)
		|=> $stable(unlock_q))
		else $error("unlock changed outside update");
	a_chain_reset: assert property (
		@(posedge sys_clk) disable iff (rst)
		reset_chain_q |-> chip_reset)
		else $error("reset chain not holding chip reset");
	a_timeout_hold: assert property (
		@(posedge sys_clk) disable iff (rst)
		$fell(chain_s) && !ext_rst_s |-> chip_reset [*8])
		else $error("reset released before time-out");
	a_disable_clear: assert property (
		@(posedge sys_clk) disable iff (rst)
		ext_rst_s && dis_q |-> ##[1:3] !dis_q)
		else $error("disable bit not cleared under reset");
	a_usable_gate: assert property (
		@(posedge sys_clk) disable iff (rst)
		port_usable |-> test_port_enable_fuse && !dis_q)
		else $error("port usable while gated");
	a_ir_update: assert property (
		@(posedge tck) disable iff (rst)
		tap_q == TAP_UPD_IR |=> ir_q == $past(ir_sh_q))
		else $error("instruction not latched on update");
	a_read_incr: assert property (
		@(posedge tck) disable iff (rst || addr_ld_t)
		tap_q == TAP_CAP_DR && ir_q == `JMP_IR_PAGE_READ && in_prog && hi_q
		|=> addr_q == $past(addr_q) + 1'b1)
		else $error("read address not advanced after high byte");
	a_load_first: assert property (
		@(posedge tck) disable iff (rst || addr_ld_t)
		tap_q == TAP_UPD_DR && ir_q == `JMP_IR_PAGE_LOAD && in_prog && first_q
		|=> addr_q == $past(addr_q) && hi_q)
		else $error("first load byte moved address");
	a_cmd_capture: assert property (
		@(posedge tck) disable iff (rst)
		tap_q == TAP_CAP_DR && ir_q == `JMP_IR_COMMAND
		|=> cmd_sh_q == $past(cmd_result))
		else $error("command result not captured");
endmodule

// File: jmp_prog_model.sv
// External programmer model: drives the test clock, mode and data pins.
// Assumes the bench calls its tasks one at a time; test clock 64 ns.
module jmp_prog_model (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// -----------------------------------------------------------
	// One test clock; data line read just before the rising edge
	// -----------------------------------------------------------
	task automatic clk1(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#32;
		o = tdo;
		tck = 1'b1;
		#32;
		tck = 1'b0;
		// Released data line shows its pull-up level
		tdi = 1'b1;
	endtask

	task automatic to_reset();
		logic o;
		repeat (6) clk1(1'b1, 1'b1, o);
		clk1(1'b0, 1'b1, o);
	endtask

	// Slow idle clocks so each event crosses on its own
	task automatic idle(input int n);
		logic o;
		repeat (n) begin
			clk1(1'b0, 1'b1, o);
			#300;
		end
	endtask

	// -----------------------------------------------------------
	// From idle: scan IR or DR, first bit in and out first
	// -----------------------------------------------------------
	task automatic scan(input logic ir, input int n,
		input logic [15:0] din, output logic [15:0] dout);
		logic o;
		dout = '0;
		clk1(1'b1, 1'b1, o);
		if (ir)
			clk1(1'b1, 1'b1, o);
		clk1(1'b0, 1'b1, o);
		clk1(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) begin
			clk1(i == n - 1, din[i], o);
			if (i > 0)
				dout[i - 1] = o;
		end
		clk1(1'b1, 1'b1, o);
		dout[n - 1] = o;
		clk1(1'b0, 1'b1, o);
	endtask
endmodule

// File: jmp_port_tb.sv
// Self-checking bench of the test-port programming block.
// Assumes jmp_cfg.svh in the include path and the programmer model.
`include "jmp_cfg.svh"
module jmp_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import jmp_pkg::*;

	logic          sys_clk = 1'b0;
	logic          rst = 1'b1;
	logic          fuse = 1'b1;
	logic          ext_n = 1'b1;
	logic          dis_set = 1'b0;
	logic          aen = 1'b0;
	logic [15:0]   aval = '0;
	logic [14:0]   res = 15'h2a5c;
	logic [7:0]    rbyte = '0;
	logic          tck;
	logic          tms_w;
	logic          tdi_w;
	jmp_pins_in_t  pin;
	jmp_pins_out_t pout;
	jmp_mem_req_t  req;
	logic          dis_bit;
	logic          usable;
	logic          chip_rst;
	logic          prog;
	int            fail_count = 0;
	int            checks = 0;
	int            nexec = 0;
	int            nld = 0;
	logic [24:0]   ld_log [0:7];
	logic [3:0]    rows [3] = '{4'b0000, 4'b1010, 4'b1101};
	logic [7:0]    pl [3] = '{8'h11, 8'h22, 8'h33};
	logic [7:0]    rd_exp [3] = '{8'h80, 8'h80, 8'h81};

	assign pin = {tms_w, tdi_w};

	always #25 sys_clk = ~sys_clk;

	jmp_port DUT (
		.sys_clk              (sys_clk),
		.rst                  (rst),
		.tck                  (tck),
		.pins_in              (pin),
		.pins_out             (pout),
		.test_port_enable_fuse(fuse),
		.ext_reset_n          (ext_n),
		.disable_set          (dis_set),
		.cmd_result           (res),
		.read_byte            (rbyte),
		.addr_load            (aval),
		.addr_load_en         (aen),
		.mem_req              (req),
		.test_port_disable_bit(dis_bit),
		.port_usable          (usable),
		.chip_reset           (chip_rst),
		.prog_mode            (prog)
	);

	jmp_prog_model u_prog (
		.tck(tck),
		.tms(tms_w),
		.tdi(tdi_w),
		.tdo(pout.tdo)
	);

	// -----------------------------------------------------------
	// Flash stand-in and memory-side monitor
	// -----------------------------------------------------------
	always @(negedge sys_clk)
		rbyte <= req.addr[7:0];

	always @(negedge sys_clk) begin
		if (req.cmd_exec === 1'b1)
			nexec <= nexec + 1;
		if (req.load_wr === 1'b1) begin
			ld_log[nld[2:0]] <= {req.load_high, req.load_data, req.addr};
			nld <= nld + 1;
		end
	end

	// -----------------------------------------------------------
	// Compare, close and watchdog
	// -----------------------------------------------------------
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// Whole run is about 25 us; twenty-four times that is a hang
	initial begin
		#600000;
		fail_count++;
		results();
	end

	// -----------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------
	initial begin
		logic [15:0] d;
		int          n0;
		cyc(4);
		rst = 1'b0;
		cyc(2);
		chk(chip_rst, 1'b0);
		chk(prog, 1'b0);
		chk(dis_bit, 1'b0);
		chk(pout.tdo_oe, 1'b0);
		chk(req, '0);
		foreach (rows[i]) begin
			{fuse, dis_set} = rows[i][3:2];
			cyc(4);
			chk(usable, rows[i][1]);
			chk(dis_bit, rows[i][0]);
		end
		dis_set = 1'b0;
		ext_n = 1'b0;
		cyc(1);
		chk(dis_bit, 1'b1);
		cyc(5);
		chk(dis_bit, 1'b0);
		chk(usable, 1'b1);
		ext_n = 1'b1;

		u_prog.to_reset();
		u_prog.scan(1'b1, 4, 16'h000c, d);
		chk(d[3:0], 4'h1);
		u_prog.scan(1'b0, 1, 16'h0001, d);
		chk(chip_rst, 1'b1);
		u_prog.scan(1'b0, 1, 16'h0000, d);
		chk(d[0], 1'b1);
		cyc(20);
		chk(chip_rst, 1'b1);
		cyc(60);
		chk(chip_rst, 1'b0);

		u_prog.scan(1'b1, 4, 16'h0004, d);
		u_prog.scan(1'b0, 16, 16'ha371, d);
		cyc(2);
		chk(prog, 1'b0);
		u_prog.scan(1'b0, 16, 16'ha370, d);
		cyc(2);
		chk(prog, 1'b1);

		u_prog.scan(1'b1, 4, 16'h0005, d);
		u_prog.scan(1'b0, 15, 16'h1234, d);
		chk(d[14:0], res);
		cyc(4);
		chk(req.cmd, 15'h1234);
		n0 = nexec;
		u_prog.idle(3);
		cyc(6);
		chk(nexec - n0, 3);

		aval = 16'h0040;
		aen = 1'b1;
		u_prog.scan(1'b1, 4, 16'h0006, d);
		cyc(1);
		aen = 1'b0;
		cyc(10);
		for (int i = 0; i < 3; i++) begin
			u_prog.scan(1'b0, 8, {8'h00, pl[i]}, d);
			cyc(14);
			chk(nld, i + 1);
		end
		chk(ld_log[0], {1'b0, 8'h11, 16'h0040});
		chk(ld_log[1], {1'b1, 8'h22, 16'h0040});
		chk(ld_log[2], {1'b0, 8'h33, 16'h0041});

		aval = 16'h0080;
		aen = 1'b1;
		u_prog.scan(1'b1, 4, 16'h0007, d);
		cyc(1);
		aen = 1'b0;
		cyc(10);
		for (int i = 0; i < 3; i++) begin
			u_prog.scan(1'b0, 8, 16'h0000, d);
			chk(d[7:0], rd_exp[i]);
			cyc(6);
		end
		chk(req.addr, 16'h0081);
		rst = 1'b1;
		cyc(1);
		chk(prog, 1'b0);
		rst = 1'b0;
		cyc(2);
		chk(chip_rst, 1'b0);
		chk(prog, 1'b0);
		results();
	end
endmodule
